// ==== inc/mic_params.svh ====
/*
 Offsets, field positions, reset values and vectors for the interrupt
 controller. Offsets are register indices; the byte address is four times
 the index on the register bus.
*/
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

`define MIC_IDX_TIMER_CTRL 8'h88
`define MIC_IDX_EXT_FLAGS 8'h91
`define MIC_IDX_UART_CFG 8'h99
`define MIC_IDX_EN_PRI 8'hA8
`define MIC_IDX_PRIO_PRI 8'hB8
`define MIC_IDX_WDT_CTRL 8'hD8
`define MIC_IDX_EN_EXT 8'hE8
`define MIC_IDX_PRIO_EXT 8'hF8

`define MIC_RESET_VAL 8'h00
`define MIC_MASK_EN_PRI 8'hBF
`define MIC_MASK_PRIO_PRI 8'h3F
`define MIC_MASK_EXT 8'h1B
`define MIC_MASK_EXT_FLAGS 8'h0B

`define MIC_BIT_GLOBAL_EN 7
`define MIC_BIT_T1_OVF 7
`define MIC_BIT_T1_RUN 6
`define MIC_BIT_T0_OVF 5
`define MIC_BIT_T0_RUN 4
`define MIC_BIT_X1_REQ 3
`define MIC_BIT_X1_EDGE 2
`define MIC_BIT_X0_REQ 1
`define MIC_BIT_X0_EDGE 0
`define MIC_BIT_UART_TX 1
`define MIC_BIT_UART_RX 0
`define MIC_BIT_WDT_FLAG 3

`define MIC_SRC_EXT0 4'h0
`define MIC_SRC_TIMER0 4'h1
`define MIC_SRC_EXT1 4'h2
`define MIC_SRC_TIMER1 4'h3
`define MIC_SRC_WDT 4'h9

`define MIC_VEC_EXT0 8'h03
`define MIC_VEC_TIMER0 8'h0B
`define MIC_VEC_EXT1 8'h13
`define MIC_VEC_TIMER1 8'h1B
`define MIC_VEC_UART 8'h23
`define MIC_VEC_TIMER2 8'h2B
`define MIC_VEC_EXT2 8'h43
`define MIC_VEC_EXT3 8'h4B
`define MIC_VEC_TCPIP 8'h5B
`define MIC_VEC_WDT 8'h63

`endif

// ==== inc/mic_pkg.sv ====
/*
 Types for the interrupt controller: source bundle and service state.
 Assumes the constants header is included alongside.
*/
package mic_pkg;

    typedef struct packed {
        logic ext0_pin;        // Pin, low active
        logic ext1_pin;        // Pin, low active
        logic ext2_pin;        // Pin, falling edge
        logic ext3_pin;        // Pin, falling edge
        logic tcpip_irq;       // Engine line, falling edge
        logic timer0_overflow; // Pulse
        logic timer1_overflow; // Pulse
        logic timer2_irq;      // Level, flag held by timer2
        logic uart_rx_done;    // Pulse
        logic uart_tx_done;    // Pulse
        logic watchdog_event;  // Pulse
    } mic_src_t;

    typedef enum logic [3:0] {
        MIC_NONE = 4'b0001,
        MIC_LOW = 4'b0010,
        MIC_HIGH = 4'b0100,
        MIC_BOTH = 4'b1000
    } mic_svc_t;

endpackage

// ==== src/mic_irq_ctrl.sv ====
/*
 Interrupt controller for an 8051-style core with a classic Wishbone
 register slave. Assumes the core pulses vector_taken while irq_req is
 high and pulses service_return on return from a routine.
*/
`timescale 1ns/1ps
`include "mic_params.svh"

module mic_irq_ctrl
    import mic_pkg::*;
(
    input wire logic clk, // 50 MHz core clock
    input wire logic rst, // Asynchronous, active high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [9:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire mic_src_t src, // Interrupt sources
    input wire logic vector_taken, // Core vectors, pulse
    input wire logic service_return, // Core returns, pulse
    output logic irq_req, // Request to core
    output logic [7:0] irq_vector, // Vector address
    output logic [3:0] irq_src, // Source number
    output logic [1:0] timer_run, // Timer 1/0 run bits
    output logic [2:0] watchdog_ctrl, // Reset flag, reset enable, restart
    output logic [5:0] uart_mode // UART config bits 7..2
);

    function automatic logic [3:0] lowest(input logic [9:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 9; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] vec_of(input logic [3:0] s);
        logic [7:0] v;
        v = `MIC_VEC_EXT0;
        case (s)
            4'h1: v = `MIC_VEC_TIMER0;
            4'h2: v = `MIC_VEC_EXT1;
            4'h3: v = `MIC_VEC_TIMER1;
            4'h4: v = `MIC_VEC_UART;
            4'h5: v = `MIC_VEC_TIMER2;
            4'h6: v = `MIC_VEC_EXT2;
            4'h7: v = `MIC_VEC_EXT3;
            4'h8: v = `MIC_VEC_TCPIP;
            4'h9: v = `MIC_VEC_WDT;
            default: v = `MIC_VEC_EXT0;
        endcase
        return v;
    endfunction

    // Set beats clear so an event in the clearing cycle survives
    function automatic logic flag_next(input logic q, input logic set,
                                       input logic wr, input logic wbit,
                                       input logic clr);
        return set | (wr ? wbit : (q & ~clr));
    endfunction

    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_prev;
    logic tc_prev;
    logic [7:0] en_pri;
    logic [7:0] prio_pri;
    logic [7:0] en_ext;
    logic [7:0] prio_ext;
    logic [1:0] edge_sel;
    logic t0f, t1f, x0f, x1f, rif, tif, x2f, x3f, tcf, wdf;
    logic irq_high;
    mic_svc_t st;
    mic_svc_t next_st;

    wire [7:0] idx = wb_adr_i[9:2];
    wire [7:0] wd = wb_dat_i[7:0];
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire wr_tmr = wr & (idx == `MIC_IDX_TIMER_CTRL);
    wire wr_xfl = wr & (idx == `MIC_IDX_EXT_FLAGS);
    wire wr_uart = wr & (idx == `MIC_IDX_UART_CFG);
    wire wr_iep = wr & (idx == `MIC_IDX_EN_PRI);
    wire wr_ipp = wr & (idx == `MIC_IDX_PRIO_PRI);
    wire wr_wdc = wr & (idx == `MIC_IDX_WDT_CTRL);
    wire wr_iex = wr & (idx == `MIC_IDX_EN_EXT);
    wire wr_ipx = wr & (idx == `MIC_IDX_PRIO_EXT);

    wire [3:0] fall = pin_prev & ~pin_s2;
    wire tc_fall = tc_prev & ~src.tcpip_irq;
    wire taken = vector_taken & irq_req;
    wire clr_x0 = taken & (irq_src == `MIC_SRC_EXT0);
    wire clr_x1 = taken & (irq_src == `MIC_SRC_EXT1);
    wire clr_t0 = taken & (irq_src == `MIC_SRC_TIMER0);
    wire clr_t1 = taken & (irq_src == `MIC_SRC_TIMER1);

    wire gie = en_pri[`MIC_BIT_GLOBAL_EN];
    wire [9:0] raw = {wdf, tcf, x3f, x2f, src.timer2_irq, rif | tif,
                      t1f, x1f, t0f, x0f};
    // Bit 2 of the extended registers is skipped entirely
    wire [9:0] en = {en_ext[4], en_ext[3], en_ext[1], en_ext[0],
                     en_pri[5:0]};
    wire [9:0] pri = {prio_ext[4], prio_ext[3], prio_ext[1], prio_ext[0],
                      prio_pri[5:0]};
    wire [9:0] pend = raw & en & {10{gie}};
    wire [9:0] hi_pend = pend & pri;
    wire [9:0] lo_pend = pend & ~pri;
    wire hi_ok = (st == MIC_NONE) | (st == MIC_LOW);
    wire take_hi = (|hi_pend) & hi_ok;
    wire take_lo = (|lo_pend) & (st == MIC_NONE);
    wire [3:0] next_src = take_hi ? lowest(hi_pend)
                                  : lowest(lo_pend);

    wire [7:0] rd_tmr = {t1f, timer_run[1], t0f, timer_run[0],
                         x1f, edge_sel[1], x0f, edge_sel[0]};
    wire [7:0] rd_mux =
        (idx == `MIC_IDX_TIMER_CTRL) ? rd_tmr :
        (idx == `MIC_IDX_EXT_FLAGS) ? {4'h0, tcf, 1'b0, x3f, x2f} :
        (idx == `MIC_IDX_UART_CFG) ? {uart_mode, tif, rif} :
        (idx == `MIC_IDX_EN_PRI) ? en_pri :
        (idx == `MIC_IDX_PRIO_PRI) ? prio_pri :
        (idx == `MIC_IDX_WDT_CTRL) ? {4'h0, wdf, watchdog_ctrl} :
        (idx == `MIC_IDX_EN_EXT) ? en_ext :
        (idx == `MIC_IDX_PRIO_EXT) ? prio_ext : 8'h00;

    always_comb
    begin
        next_st = st;
        if (taken)
        begin
            unique case (st)
                MIC_NONE: next_st = irq_high ? MIC_HIGH : MIC_LOW;
                MIC_LOW: next_st = MIC_BOTH;
                MIC_HIGH: next_st = MIC_HIGH;
                MIC_BOTH: next_st = MIC_BOTH;
            endcase
        end
        else if (service_return)
        begin
            unique case (st)
                MIC_NONE: next_st = MIC_NONE;
                MIC_LOW: next_st = MIC_NONE;
                MIC_HIGH: next_st = MIC_NONE;
                MIC_BOTH: next_st = MIC_LOW;
            endcase
        end
    end

    // Bus slave: ack one cycle after strobe, write lands at the ack edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req & ~wb_ack_o)
            begin
                wb_dat_o <= {24'h0, rd_mux};
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1 <= 4'hF;
            pin_s2 <= 4'hF;
            pin_prev <= 4'hF;
            tc_prev <= 1'b0;
        end
        else
        begin
            pin_s1 <= {src.ext3_pin, src.ext2_pin, src.ext1_pin,
                       src.ext0_pin};
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
            tc_prev <= src.tcpip_irq;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_pri <= `MIC_RESET_VAL;
            prio_pri <= `MIC_RESET_VAL;
            en_ext <= `MIC_RESET_VAL;
            prio_ext <= `MIC_RESET_VAL;
            edge_sel <= 2'h0;
            timer_run <= 2'h0;
            watchdog_ctrl <= 3'h0;
            uart_mode <= 6'h00;
        end
        else
        begin
            if (wr_iep)
                en_pri <= wd & `MIC_MASK_EN_PRI;
            if (wr_ipp)
                prio_pri <= wd & `MIC_MASK_PRIO_PRI;
            if (wr_iex)
                en_ext <= wd & `MIC_MASK_EXT;
            if (wr_ipx)
                prio_ext <= wd & `MIC_MASK_EXT;
            if (wr_tmr)
            begin
                edge_sel <= {wd[`MIC_BIT_X1_EDGE],
                             wd[`MIC_BIT_X0_EDGE]};
                timer_run <= {wd[`MIC_BIT_T1_RUN], wd[`MIC_BIT_T0_RUN]};
            end
            if (wr_wdc)
                watchdog_ctrl <= wd[2:0];
            if (wr_uart)
                uart_mode <= wd[7:2];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {t0f, t1f, x0f, x1f, rif, tif, x2f, x3f, tcf, wdf} <= 10'h000;
        end
        else
        begin
            t0f <= flag_next(t0f, src.timer0_overflow, wr_tmr,
                             wd[`MIC_BIT_T0_OVF], clr_t0);
            t1f <= flag_next(t1f, src.timer1_overflow, wr_tmr,
                             wd[`MIC_BIT_T1_OVF], clr_t1);
            // Level mode tracks the pin and ignores software
            x0f <= edge_sel[0] ? flag_next(x0f, fall[0], wr_tmr,
                   wd[`MIC_BIT_X0_REQ], clr_x0) : ~pin_s2[0];
            x1f <= edge_sel[1] ? flag_next(x1f, fall[1], wr_tmr,
                   wd[`MIC_BIT_X1_REQ], clr_x1) : ~pin_s2[1];
            rif <= flag_next(rif, src.uart_rx_done, wr_uart,
                             wd[`MIC_BIT_UART_RX], 1'b0);
            tif <= flag_next(tif, src.uart_tx_done, wr_uart,
                             wd[`MIC_BIT_UART_TX], 1'b0);
            x2f <= flag_next(x2f, fall[2], wr_xfl, wd[0], 1'b0);
            x3f <= flag_next(x3f, fall[3], wr_xfl, wd[1], 1'b0);
            tcf <= flag_next(tcf, tc_fall, wr_xfl, wd[3], 1'b0);
            // Only software clears, through a write to the watchdog control index
            wdf <= flag_next(wdf, src.watchdog_event, wr_wdc,
                             wd[`MIC_BIT_WDT_FLAG], 1'b0);
        end
    end

    // Request drops in the vectoring cycle so the state settles first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= MIC_NONE;
            irq_req <= 1'b0;
            irq_src <= 4'h0;
            irq_high <= 1'b0;
            irq_vector <= `MIC_VEC_EXT0;
        end
        else
        begin
            st <= next_st;
            irq_req <= (take_hi | take_lo) & ~taken;
            irq_src <= next_src;
            irq_high <= take_hi;
            irq_vector <= vec_of(next_src);
        end
    end

    AST_GLOBAL_OFF: assert property (@(posedge clk) disable iff (rst)
        !gie |=> !irq_req)
        else $error("request while global enable is off");

    // Indexed by next_src: irq_src only takes that value one edge later
    AST_EN_GATE: assert property (@(posedge clk) disable iff (rst)
        irq_req |-> $past(raw[next_src] & en[next_src]))
        else $error("request from a disabled source");

    AST_EN_BIT6: assert property (@(posedge clk) disable iff (rst)
        wr_iep |=> en_pri[6] == 1'b0 && en_pri[5:0] == $past(wd[5:0]))
        else $error("primary enable write wrong");

    AST_SW_SET: assert property (@(posedge clk) disable iff (rst)
        wr_tmr && wd[`MIC_BIT_T0_OVF] |=> t0f ##1 (t0f || $past(clr_t0)))
        else $error("software set of timer0 flag lost");

    AST_LEVEL: assert property (@(posedge clk) disable iff (rst)
        !edge_sel[0] ##1 !edge_sel[0] |-> x0f == $past(~pin_s2[0]))
        else $error("level flag does not follow pin");

    AST_EDGE: assert property (@(posedge clk) disable iff (rst)
        edge_sel[0] && fall[0] |=> x0f)
        else $error("falling edge missed");

    AST_AUTOCLR: assert property (@(posedge clk) disable iff (rst)
        clr_t1 && !src.timer1_overflow |=> !t1f)
        else $error("timer1 flag not cleared on vectoring");

    AST_EXT_STICKY: assert property (@(posedge clk)
        disable iff (rst) x2f && !wr_xfl |=> x2f)
        else $error("ext2 flag cleared without software");

    AST_WDT_STICKY: assert property (@(posedge clk)
        disable iff (rst) wdf && !wr_wdc |=> wdf)
        else $error("watchdog flag cleared by hardware");

    AST_WDT_VEC: assert property (@(posedge clk) disable iff (rst)
        irq_req && irq_src == `MIC_SRC_WDT |-> irq_vector == `MIC_VEC_WDT)
        else $error("watchdog vector wrong");

    AST_PREEMPT: assert property (@(posedge clk) disable iff (rst)
        st == MIC_LOW && (|hi_pend) && !taken |=> irq_req && irq_high)
        else $error("high priority did not preempt");

    AST_WB_ACK: assert property (@(posedge clk) disable iff (rst)
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle");

    COV_PREEMPT: cover property (@(posedge clk) disable iff (rst)
        st == MIC_LOW ##1 st == MIC_BOTH);
    COV_WDT: cover property (@(posedge clk) disable iff (rst)
        irq_req && irq_src == `MIC_SRC_WDT);
    COV_EDGE_TAKE: cover property (@(posedge clk) disable iff (rst)
        clr_x0 && edge_sel[0]);

endmodule // mic_irq_ctrl

// ==== tb/mic_core_model.sv ====
/*
 Core-side partner: vectors after a bench-chosen delay, returns on request.
 Assumes the controller holds irq_req until vector_taken is seen.
*/
`timescale 1ns/1ps

module mic_core_model
(
    input wire logic clk, // Core clock
    input wire logic rst, // Active high
    input wire logic irq_req, // Request from controller
    input wire logic [7:0] irq_vector, // Offered vector
    input wire logic [3:0] irq_src, // Offered source
    input wire logic accept, // Bench lets the core vector
    input wire logic [3:0] delay, // Wait cycles before vectoring
    input wire logic do_return, // Bench asks for a return
    output logic vector_taken, // Pulse
    output logic service_return, // Pulse
    output logic [7:0] got_vec, // Last taken vector
    output logic [3:0] got_src, // Last taken source
    output logic [7:0] n_taken // Vectors taken
);
    logic [3:0] wait_cnt;

    // A slow core lets the request sit; a vanished request restarts the wait
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vector_taken <= 1'b0;
            service_return <= 1'b0;
            wait_cnt <= 4'h0;
            got_vec <= 8'h00;
            got_src <= 4'h0;
            n_taken <= 8'h00;
        end
        else
        begin
            vector_taken <= 1'b0;
            service_return <= do_return;
            if (!irq_req || !accept || vector_taken)
                wait_cnt <= 4'h0;
            else if (wait_cnt != delay)
                wait_cnt <= wait_cnt + 4'h1;
            else
            begin
                vector_taken <= 1'b1;
                got_vec <= irq_vector;
                got_src <= irq_src;
                n_taken <= n_taken + 8'h01;
            end
        end
    end
endmodule // mic_core_model

// ==== tb/mic_interrupt_control_tb.sv ====
/*
 Self-checking bench: Wishbone register tasks, a core partner model and
 sources driven from the bench. Assumes the controller's hand-over timing.
*/
`timescale 1ns/1ps
`include "mic_params.svh"

module mic_interrupt_control_tb
    import mic_pkg::*;
;
    logic clk, rst, cyc, stb, we, wb_ack_o, irq_req, accept, do_return;
    logic vector_taken, service_return;
    logic [3:0] sel, irq_src, delay, got_src;
    logic [9:0] adr;
    logic [31:0] wdat, wb_dat_o;
    logic [7:0] irq_vector, got_vec, n_taken, d;
    logic [1:0] timer_run;
    logic [2:0] watchdog_ctrl;
    logic [5:0] uart_mode;
    mic_src_t src;
    int n_fail, total_checks;
    logic [7:0] r_idx [9] = '{`MIC_IDX_TIMER_CTRL, `MIC_IDX_EXT_FLAGS,
        `MIC_IDX_UART_CFG, `MIC_IDX_EN_PRI, `MIC_IDX_PRIO_PRI,
        `MIC_IDX_WDT_CTRL, `MIC_IDX_EN_EXT, `MIC_IDX_PRIO_EXT, 8'h00};
    logic [7:0] r_wr [9] = '{8'h54, 8'hFB, 8'hA4, 8'hFF, 8'hFF, 8'h07,
        8'hFB, 8'hFB, 8'hFF};
    logic [7:0] r_rd [9] = '{8'h54, 8'h0B, 8'hA4, 8'hBF, 8'h3F, 8'h07,
        8'h1B, 8'h1B, 8'h00};
    logic [7:0] f_idx [7] = '{`MIC_IDX_TIMER_CTRL, `MIC_IDX_TIMER_CTRL,
        `MIC_IDX_UART_CFG, `MIC_IDX_EXT_FLAGS, `MIC_IDX_EXT_FLAGS,
        `MIC_IDX_EXT_FLAGS, `MIC_IDX_WDT_CTRL};
    logic [7:0] f_val [7] = '{8'h20, 8'h80, 8'h01, 8'h01, 8'h02, 8'h08, 8'h08};
    logic [7:0] f_aft [7] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h08, 8'h08};
    logic [7:0] f_pen [7] = '{8'h82, 8'h88, 8'h90, 8'h80, 8'h80, 8'h80, 8'h80};
    logic [7:0] f_een [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h08, 8'h10};
    logic [7:0] f_vec [7] = '{`MIC_VEC_TIMER0, `MIC_VEC_TIMER1, `MIC_VEC_UART,
        `MIC_VEC_EXT2, `MIC_VEC_EXT3, `MIC_VEC_TCPIP, `MIC_VEC_WDT};
    logic [3:0] f_src [7] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};

    mic_irq_ctrl i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src(src),
        .vector_taken(vector_taken), .service_return(service_return),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_src(irq_src),
        .timer_run(timer_run), .watchdog_ctrl(watchdog_ctrl),
        .uart_mode(uart_mode));

    mic_core_model i_core (.clk(clk), .rst(rst), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_src(irq_src), .accept(accept),
        .delay(delay), .do_return(do_return), .vector_taken(vector_taken),
        .service_return(service_return), .got_vec(got_vec),
        .got_src(got_src), .n_taken(n_taken));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wb_access(input logic [7:0] idx, input logic wr_en,
        input logic [7:0] data, input logic [3:0] lanes,
        output logic [7:0] rdata);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr_en;
        sel <= lanes;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, data};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rdata = wb_dat_o[7:0];
        check({31'h0, wb_ack_o}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        logic [7:0] q;
        wb_access(idx, 1'b1, data, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        wb_access(idx, 1'b0, 8'h00, 4'hF, q);
        check({24'h0, q}, {24'h0, exp});
    endtask

    task automatic no_req(input int cycles);
        repeat (cycles) @(posedge clk);
        check({31'h0, irq_req}, 32'h0);
    endtask

    task automatic take(input logic [7:0] vec, input logic [3:0] num);
        logic [7:0] n0;
        int n;
        n0 = n_taken;
        n = 0;
        accept <= 1'b1;
        while (n_taken === n0 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        accept <= 1'b0;
        check({24'h0, got_vec}, {24'h0, vec});
        check({28'h0, got_src}, {28'h0, num});
    endtask

    task automatic ret();
        @(posedge clk);
        do_return <= 1'b1;
        @(posedge clk);
        do_return <= 1'b0;
    endtask

    initial
    begin
        #1_000_000;
        n_fail++;
        final_report();
    end

    initial
    begin
        rst = 1'b1;
        {cyc, stb, we, accept, do_return} = 5'h00;
        {sel, delay, adr, wdat} = '0;
        // Pins idle high, pulses low
        src = mic_src_t'(11'h7C0);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++)
            rd_chk(r_idx[i], 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            wr(r_idx[i], r_wr[i]);
            rd_chk(r_idx[i], r_rd[i]);
        end
        check({30'h0, timer_run}, 32'h3);
        check({29'h0, watchdog_ctrl}, 32'h7);
        check({26'h0, uart_mode}, 32'h29);
        wb_access(`MIC_IDX_EN_PRI, 1'b1, 8'h00, 4'hE, d);
        rd_chk(`MIC_IDX_EN_PRI, 8'hBF);
        for (int i = 8; i >= 0; i--)
            wr(r_idx[i], 8'h00);
        // Software-set flags, each with its own enable and vector
        for (int i = 0; i < 7; i++)
        begin
            delay <= 4'(i);
            wr(f_idx[i], f_val[i]);
            no_req(4);
            wr(`MIC_IDX_EN_EXT, f_een[i]);
            wr(`MIC_IDX_EN_PRI, f_pen[i] & 8'h7F);
            no_req(4);
            wr(`MIC_IDX_EN_PRI, f_pen[i]);
            take(f_vec[i], f_src[i]);
            rd_chk(f_idx[i], f_aft[i]);
            wr(f_idx[i], 8'h00);
            ret();
            wr(`MIC_IDX_EN_PRI, 8'h00);
            wr(`MIC_IDX_EN_EXT, 8'h00);
        end
        // A pending request cancelled by software
        wr(`MIC_IDX_EN_PRI, 8'h82);
        wr(`MIC_IDX_TIMER_CTRL, 8'h20);
        wr(`MIC_IDX_TIMER_CTRL, 8'h00);
        no_req(3);
        // Level mode on external 0
        wr(`MIC_IDX_EN_PRI, 8'h81);
        src.ext0_pin <= 1'b0;
        take(`MIC_VEC_EXT0, `MIC_SRC_EXT0);
        rd_chk(`MIC_IDX_TIMER_CTRL, 8'h02);
        wr(`MIC_IDX_TIMER_CTRL, 8'h00);
        rd_chk(`MIC_IDX_TIMER_CTRL, 8'h02);
        src.ext0_pin <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`MIC_IDX_TIMER_CTRL, 8'h00);
        ret();
        // Edge mode: the flag outlives the pin and clears on vectoring
        wr(`MIC_IDX_TIMER_CTRL, 8'h01);
        src.ext0_pin <= 1'b0;
        repeat (3) @(posedge clk);
        src.ext0_pin <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`MIC_IDX_TIMER_CTRL, 8'h03);
        take(`MIC_VEC_EXT0, `MIC_SRC_EXT0);
        rd_chk(`MIC_IDX_TIMER_CTRL, 8'h01);
        ret();
        // Equal priority by polling order, then a high one preempts
        wr(`MIC_IDX_EN_PRI, 8'hA3);
        wr(`MIC_IDX_PRIO_PRI, 8'h20);
        src.ext0_pin <= 1'b0;
        src.timer0_overflow <= 1'b1;
        @(posedge clk);
        src.timer0_overflow <= 1'b0;
        repeat (2) @(posedge clk);
        src.ext0_pin <= 1'b1;
        take(`MIC_VEC_EXT0, `MIC_SRC_EXT0);
        no_req(5);
        src.timer2_irq <= 1'b1;
        take(`MIC_VEC_TIMER2, 4'h5);
        src.timer2_irq <= 1'b0;
        ret();
        no_req(4);
        ret();
        take(`MIC_VEC_TIMER0, `MIC_SRC_TIMER0);
        ret();
        wr(`MIC_IDX_EN_PRI, 8'h00);
        wr(`MIC_IDX_TIMER_CTRL, 8'h00);
        // Hardware sets; extended flags survive the source going away
        {src.ext2_pin, src.ext3_pin, src.tcpip_irq} <= 3'b000;
        {src.timer1_overflow, src.uart_rx_done} <= 2'b11;
        {src.uart_tx_done, src.watchdog_event} <= 2'b11;
        @(posedge clk);
        {src.timer1_overflow, src.uart_rx_done} <= 2'b00;
        {src.uart_tx_done, src.watchdog_event} <= 2'b00;
        {src.ext2_pin, src.ext3_pin, src.tcpip_irq} <= 3'b111;
        repeat (5) @(posedge clk);
        rd_chk(`MIC_IDX_EXT_FLAGS, 8'h0B);
        rd_chk(`MIC_IDX_UART_CFG, 8'h03);
        rd_chk(`MIC_IDX_WDT_CTRL, 8'h08);
        rd_chk(`MIC_IDX_TIMER_CTRL, 8'h80);
        final_report();
    end
endmodule // mic_interrupt_control_tb
